// ---- bench/adc_control_and_flags_properties.sv ----
// Bus timing, gating and decode checks for the ADC control and flag block.
// Assumes one AHB-Lite master whose hready is the block's own hreadyout.
module adc_control_and_flags_properties
	import adc_ctrl_pkg::*;
#(
	parameter int CNT_W = 5
) (
	input wire logic        hclk,             // Clock
	input wire logic        hresetn,          // Reset, low
	input wire logic        hsel,             // Select
	input wire logic [31:0] haddr,            // Address
	input wire logic [1:0]  htrans,           // Transfer
	input wire logic        hwrite,           // Write
	input wire logic [2:0]  hsize,            // Size
	input wire logic [31:0] hwdata,           // Write data
	input wire logic        hready,           // Ready in
	input wire logic        hreadyout,        // Ready out
	input wire logic        hresp,            // Response
	input wire logic [31:0] hrdata,           // Read data
	input wire adc_events_t done,             // Strobes
	input wire logic [15:0] curr_accum_level, // Result
	input wire logic        global_irq_en,    // Global enable
	input wire logic [7:0]  vector_taken,     // Vector ack
	input wire adc_cfg_t    cfg,              // Config
	input wire logic [7:0]  irq_req           // Requests
);
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	wire taken = hsel & hready & htrans[1];
	// A read costs exactly one wait state
	sequence read_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	chk_read_wait: assert property (taken && !hwrite |=> read_wait)
		else $error("read wait state wrong");
	chk_write_nowait: assert property (taken && hwrite |=> hreadyout)
		else $error("write stalled");
	chk_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	chk_global_gate: assert property (!global_irq_en |-> irq_req == 8'h00)
		else $error("request without global enable");
	chk_reserved_irq: assert property (irq_req[7:6] == 2'h0 && !irq_req[3])
		else $error("request on reserved bit");
	chk_rdata_upper: assert property (hrdata[31:8] == 24'h000000)
		else $error("upper read data not zero");
	chk_vector_clear: assert property (vector_taken[1] && !done.curr_accum_done |=> !irq_req[1])
		else $error("vector did not clear flag");
	chk_ground_in1: assert property (cfg.input1_as_signal_ground == (cfg.voltage_channel_sel == CH_IN0_SIGNAL_GROUND))
		else $error("input1 ground decode wrong");
	chk_ground_in0: assert property (cfg.input0_as_signal_ground == (cfg.voltage_channel_sel == CH_IN1_SIGNAL_GROUND))
		else $error("input0 ground decode wrong");
endmodule : adc_control_and_flags_properties

bind adc_control_and_flags adc_control_and_flags_properties #(.CNT_W(CNT_W)) u_chk (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .done(done), .curr_accum_level(curr_accum_level),
	.global_irq_en(global_irq_en), .vector_taken(vector_taken), .cfg(cfg), .irq_req(irq_req));

// ---- bench/adc_control_and_flags_tb.sv ----
// Self-checking bench for the ADC control and flag block over AHB-Lite.
// Assumes the converter model and the bound checker are compiled alongside.
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin bad_count++; \
	$display("[FAIL] %s exp %h got %h", n, e, s); end end
`define A(i) {22'h0, i, 2'h0}
module adc_control_and_flags_tb;
	import adc_ctrl_pkg::*;
	timeunit 1ns;
	timeprecision 100ps;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, global_irq_en = 0;
	logic [31:0] haddr = '0, hwdata = '0, hrdata;
	logic [1:0]  htrans = '0;
	logic [2:0]  hsize = 3'h2;
	logic [7:0]  vector_taken = '0, rd, irq_req;
	logic        hreadyout, hresp;
	logic [15:0] lvl;
	adc_cfg_t    cfg;
	adc_events_t done;
	int          bad_count = 0, num_checks = 0;
	always #2.5 hclk = ~hclk;
	adc_core_model core (.hclk(hclk), .done(done), .curr_accum_level(lvl));
	adc_control_and_flags #(.CNT_W(5)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.done(done), .curr_accum_level(lvl), .global_irq_en(global_irq_en),
		.vector_taken(vector_taken), .cfg(cfg), .irq_req(irq_req));
	task automatic bus(input logic [31:0] a, input logic w, input logic [7:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata[7:0];
		// Let the closing edge's register updates settle before callers look at cfg
		#1;
	endtask : bus
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		bus(`A(i), 1'b1, d);
	endtask : wr
	task automatic rdc(input logic [7:0] i, input logic [7:0] e);
		bus(`A(i), 1'b0, 8'h00);
		`CHK("register", e, rd)
	endtask : rdc
	task automatic t_reset;
		bus(32'h0000_0790, 1'b1, 8'hff);
		for (int i = 0; i < 8; i++) rdc(8'he4 + 8'(i), 8'h00);
	endtask : t_reset
	task automatic t_ctrl;
		wr(IDX_CURR_CTRL, 8'hff);
		rdc(IDX_CURR_CTRL, 8'hbf);
		`CHK("cur_on", 1'b1, cfg.current_conv_on)
		for (int c = 0; c < 8; c++) begin
			wr(IDX_CURR_GAIN, {2'h0, 3'(c), 2'(c), c[0]});
			wr(IDX_VOLT_CTRL, {c[1], 1'b1, c[0], 2'(c), 3'(c)});
			`CHK("gain", 3'(c), cfg.current_gain_code)
			`CHK("cpull", 2'(c), cfg.current_diag_pullup_sel)
			`CHK("cdiag", c[0], cfg.current_diag_input_sel)
			`CHK("von", c[1], cfg.voltage_conv_on)
			`CHK("vref", c[0], cfg.voltage_ref_sel)
			`CHK("vpull", 2'(c), cfg.voltage_diag_pullup_sel)
			`CHK("chan", 3'(c), cfg.voltage_channel_sel)
			`CHK("gnd1", c == 1, cfg.input1_as_signal_ground)
			`CHK("gnd0", c == 2, cfg.input0_as_signal_ground)
		end
		rdc(IDX_VOLT_CTRL, 8'hbf);
		wr(IDX_CURR_CTRL, 8'h00);
		`CHK("cur_off", 1'b0, cfg.current_conv_on)
	endtask : t_ctrl
	task automatic t_flags;
		wr(IDX_MASK, 8'hff);
		rdc(IDX_MASK, 8'h37);
		global_irq_en <= 1'b1;
		core.fire(4'hf, 16'h0000);
		rdc(IDX_FLAGS, 8'h33);
		`CHK("irq", 8'h33, irq_req)
		global_irq_en <= 1'b0;
		@(posedge hclk);
		#1 `CHK("irq_off", 8'h00, irq_req)
		global_irq_en <= 1'b1;
		// Plain writes only: reading back and rewriting would drop pending flags
		wr(IDX_FLAGS, 8'h00);
		rdc(IDX_FLAGS, 8'h33);
		wr(IDX_FLAGS, 8'h01);
		rdc(IDX_FLAGS, 8'h32);
		vector_taken <= 8'h02;
		@(posedge hclk);
		vector_taken <= 8'h00;
		rdc(IDX_FLAGS, 8'h30);
		wr(IDX_FLAGS, 8'hff);
	endtask : t_flags
	task automatic res(input logic up, input logic e);
		core.fire(4'h2, up ? 16'h0011 : 16'h0010);
		#1 `CHK("rc_flag", e, irq_req[2])
	endtask : res
	task automatic seq(input logic [5:0] up, input logic [5:0] ex, input int n);
		for (int i = 0; i < n; i++) res(up[i], ex[i]);
	endtask : seq
	task automatic t_cmp;
		wr(IDX_LEVEL_HI, 8'hff);
		rdc(IDX_LEVEL_HI, 8'h7f);
		wr(IDX_LEVEL_HI, 8'h00);
		wr(IDX_LEVEL_LO, 8'h10);
		wr(IDX_CURR_CTRL, 8'h12);
		seq(6'b111011, 6'b100000, 6);
		wr(IDX_FLAGS, 8'h04);
		wr(IDX_CURR_CTRL, 8'h30);
		seq(6'b111111, 6'b000000, 6);
		wr(IDX_CURR_CTRL, 8'h22);
		seq(6'b011011, 6'b010000, 5);
		wr(IDX_FLAGS, 8'h04);
		res(1'b1, 1'b0);
		wr(IDX_CURR_CTRL, 8'h00);
	endtask : t_cmp
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_ctrl();
		t_flags();
		t_cmp();
		give_verdict();
	end
	initial begin
		#50us;
		bad_count++;
		give_verdict();
	end
endmodule : adc_control_and_flags_tb

// ---- bench/adc_core_model.sv ----
// Behavioural stand-in for the two converter cores: conversion strobes and result.
// Assumes the caller runs one conversion at a time on hclk.
module adc_core_model
	import adc_ctrl_pkg::*;
(
	input  wire logic  hclk,             // Clock
	output adc_events_t done,            // Strobes
	output logic [15:0] curr_accum_level // Result
);
	initial done = '0;
	initial curr_accum_level = 16'h0000;
	task automatic fire(input adc_events_t ev, input logic [15:0] lv);
		@(posedge hclk);
		done <= ev;
		curr_accum_level <= lv;
		@(posedge hclk);
		done <= '0;
		// Result only valid with its strobe; show garbage after
		curr_accum_level <= ~lv;
	endtask : fire
endmodule : adc_core_model

// ---- rtl/adc_control_and_flags.sv ----
// Control registers, regular-current comparator and interrupt flags of a
// dual sigma-delta ADC front end, behind an AHB-Lite slave port.
// Assumes done strobes are one-cycle pulses on hclk, result level valid with them.
module adc_control_and_flags
	import adc_ctrl_pkg::*;
#(
	parameter int CNT_W = 5
) (
	input  wire logic        hclk,              // System clock
	input  wire logic        hresetn,           // Async reset, active low
	input  wire logic        hsel,              // Slave select
	input  wire logic [31:0] haddr,             // Byte address
	input  wire logic [1:0]  htrans,            // Transfer type
	input  wire logic        hwrite,            // Write when high
	input  wire logic [2:0]  hsize,             // Transfer size, word only
	input  wire logic [31:0] hwdata,            // Write data
	input  wire logic        hready,            // Bus ready
	output logic             hreadyout,         // Slave ready
	output logic             hresp,             // Always OKAY
	output logic [31:0]      hrdata,            // Read data
	input  wire adc_events_t done,              // Conversion-complete strobes
	input  wire logic [15:0] curr_accum_level,  // Accumulated current result
	input  wire logic        global_irq_en,     // Global interrupt enable bit
	input  wire logic [7:0]  vector_taken,      // Vector executed, per flag bit
	output adc_cfg_t         cfg,               // Converter configuration
	output logic [7:0]       irq_req            // Interrupt requests, per flag bit
);

	logic [7:0]       curr_ctrl_reg;
	logic [7:0]       curr_gain_reg;
	logic [7:0]       volt_ctrl_reg;
	logic [7:0]       flags_reg;
	logic [7:0]       mask_reg;
	logic [7:0]       level_lo_reg;
	logic [7:0]       level_hi_reg;
	logic             wr_pend_reg;
	logic [7:0]       wr_idx_reg;
	logic             rd_wait_reg;
	logic [7:0]       rd_idx_reg;
	logic [31:0]      hrdata_reg;
	logic [CNT_W-1:0] rc_cnt_reg;
	logic [CNT_W-1:0] rc_cnt_next;

	// Offsets above the register window are unmapped
	function automatic logic addr_ok(input logic [31:0] a);
		return (a[31:10] == 22'h000000) && (a[1:0] == 2'h0);
	endfunction : addr_ok

	function automatic logic [7:0] read_mux(
		input logic [7:0] idx,
		input logic [7:0] c0, c1, c2, fl, mk, lo, hi
	);
		case (idx)
			IDX_CURR_CTRL: return c0;
			IDX_CURR_GAIN: return c1;
			IDX_VOLT_CTRL: return c2;
			IDX_FLAGS:     return fl;
			IDX_MASK:      return mk;
			IDX_LEVEL_LO:  return lo;
			IDX_LEVEL_HI:  return hi;
			default:       return 8'h00;
		endcase
	endfunction : read_mux

	// Bus decode
	wire       take      = hsel & hready & htrans[1];
	wire       take_wr   = take & hwrite;
	wire       take_rd   = take & ~hwrite;
	wire [7:0] acc_idx   = addr_ok(haddr) ? haddr[9:2] : 8'h00;
	wire [7:0] wdat      = hwdata[7:0];
	wire       wr_c0     = wr_pend_reg & (wr_idx_reg == IDX_CURR_CTRL);
	wire       wr_c1     = wr_pend_reg & (wr_idx_reg == IDX_CURR_GAIN);
	wire       wr_c2     = wr_pend_reg & (wr_idx_reg == IDX_VOLT_CTRL);
	wire       wr_fl     = wr_pend_reg & (wr_idx_reg == IDX_FLAGS);
	wire       wr_mk     = wr_pend_reg & (wr_idx_reg == IDX_MASK);
	wire       wr_lo     = wr_pend_reg & (wr_idx_reg == IDX_LEVEL_LO);
	wire       wr_hi     = wr_pend_reg & (wr_idx_reg == IDX_LEVEL_HI);
	wire [7:0] rd_value  = read_mux(rd_idx_reg, curr_ctrl_reg, curr_gain_reg,
		volt_ctrl_reg, flags_reg, mask_reg, level_lo_reg, level_hi_reg);

	// Reads take one wait state so a write just ahead is already visible
	assign hreadyout = ~rd_wait_reg;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;

	// Comparator
	wire [1:0]       cmp_mode   = curr_ctrl_reg[CMP_MODE_LSB +: 2];
	wire [15:0]      level      = {level_hi_reg, level_lo_reg};
	wire             cmp_active = (cmp_mode == CMP_RESET_MODE) ||
		(cmp_mode == CMP_UPDOWN);
	wire             above      = curr_accum_level > level;
	wire [CNT_W-1:0] target     = CNT_W'(curr_ctrl_reg[SAMPLE_CNT_LSB +: 4]) +
		CNT_W'(1);
	wire             rc_hit     = cmp_active & done.curr_accum_done & above &
		(rc_cnt_reg != target) & (rc_cnt_reg + CNT_W'(1) == target);

	always_comb begin
		rc_cnt_next = rc_cnt_reg;
		if (!cmp_active) begin
			rc_cnt_next = '0;
		end else if (done.curr_accum_done) begin
			if (above) begin
				if (rc_cnt_reg != target)
					rc_cnt_next = rc_cnt_reg + CNT_W'(1);
			end else if (cmp_mode == CMP_RESET_MODE) begin
				rc_cnt_next = '0;
			end else if (rc_cnt_reg != '0) begin
				rc_cnt_next = rc_cnt_reg - CNT_W'(1);
			end
		end
	end

	// Flag events, clears and next value; a set beats a clear in the same cycle
	wire [7:0] flag_set = (8'(done.volt_accum_done)   << FLAG_VACC_BIT) |
		(8'(done.volt_instant_done) << FLAG_VINST_BIT) |
		(8'(rc_hit)                 << FLAG_RC_BIT) |
		(8'(done.curr_accum_done)   << FLAG_CACC_BIT) |
		(8'(done.curr_instant_done) << FLAG_CINST_BIT);
	wire [7:0] flag_clr = (wr_fl ? wdat : 8'h00) | vector_taken;
	wire [7:0] flags_next = ((flags_reg & ~flag_clr) | flag_set) & WMASK_FLAGS;

	assign irq_req = flags_reg & mask_reg & {8{global_irq_en}};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			wr_idx_reg  <= 8'h00;
			rd_wait_reg <= 1'b0;
			rd_idx_reg  <= 8'h00;
			hrdata_reg  <= 32'h00000000;
		end else begin
			wr_pend_reg <= take_wr;
			wr_idx_reg  <= acc_idx;
			rd_wait_reg <= take_rd;
			rd_idx_reg  <= acc_idx;
			if (rd_wait_reg)
				hrdata_reg <= {24'h000000, rd_value};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			curr_ctrl_reg <= RST_CTRL;
			curr_gain_reg <= RST_CTRL;
			volt_ctrl_reg <= RST_CTRL;
			mask_reg      <= RST_CTRL;
			level_lo_reg  <= RST_CTRL;
			level_hi_reg  <= RST_CTRL;
		end else begin
			if (wr_c0)
				curr_ctrl_reg <= wdat & WMASK_CURR_CTRL;
			if (wr_c1)
				curr_gain_reg <= wdat & WMASK_CURR_GAIN;
			if (wr_c2)
				volt_ctrl_reg <= wdat & WMASK_VOLT_CTRL;
			if (wr_mk)
				mask_reg <= wdat & WMASK_FLAGS;
			if (wr_lo)
				level_lo_reg <= wdat;
			if (wr_hi)
				level_hi_reg <= wdat & WMASK_LEVEL_HI;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_reg  <= RST_FLAGS;
			rc_cnt_reg <= '0;
		end else begin
			flags_reg  <= flags_next;
			rc_cnt_reg <= rc_cnt_next;
		end
	end

	// Configuration to the analog cores, straight from the registers
	wire [2:0] chan = volt_ctrl_reg[CHANNEL_LSB +: 3];
	assign cfg.current_conv_on         = curr_ctrl_reg[CONV_ON_BIT];
	assign cfg.current_gain_code       = curr_gain_reg[GAIN_LSB +: 3];
	assign cfg.current_diag_pullup_sel = curr_gain_reg[DIAG_PULLUP_LSB +: 2];
	assign cfg.current_diag_input_sel  = curr_gain_reg[DIAG_INPUT_BIT];
	assign cfg.voltage_conv_on         = volt_ctrl_reg[CONV_ON_BIT];
	assign cfg.voltage_ref_sel         = volt_ctrl_reg[REF_SEL_BIT];
	assign cfg.voltage_diag_pullup_sel = volt_ctrl_reg[VDIAG_PULLUP_LSB +: 2];
	assign cfg.voltage_channel_sel     = chan;
	assign cfg.input1_as_signal_ground = (chan == CH_IN0_SIGNAL_GROUND);
	assign cfg.input0_as_signal_ground = (chan == CH_IN1_SIGNAL_GROUND);

endmodule : adc_control_and_flags

// ---- rtl/adc_ctrl_pkg.sv ----
// Constants and carrier types for the ADC control and flag block.
// Assumes one AHB-Lite slave; each 8-bit register sits in the low byte of a word.
package adc_ctrl_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_CURR_CTRL  = 8'he4;
	localparam logic [7:0] IDX_CURR_GAIN  = 8'he5;
	localparam logic [7:0] IDX_VOLT_CTRL  = 8'he6;
	localparam logic [7:0] IDX_FLAGS      = 8'he7;
	localparam logic [7:0] IDX_MASK       = 8'he8;
	localparam logic [7:0] IDX_LEVEL_LO   = 8'he9;
	localparam logic [7:0] IDX_LEVEL_HI   = 8'hea;

	// Reset values
	localparam logic [7:0] RST_CTRL       = 8'h00;
	localparam logic [7:0] RST_FLAGS      = 8'h00;

	// Writable / readable bits of each register
	localparam logic [7:0] WMASK_CURR_CTRL = 8'hbf;
	localparam logic [7:0] WMASK_CURR_GAIN = 8'h3f;
	localparam logic [7:0] WMASK_VOLT_CTRL = 8'hbf;
	localparam logic [7:0] WMASK_FLAGS     = 8'h37;
	localparam logic [7:0] WMASK_LEVEL_HI  = 8'h7f;

	// Field positions
	localparam int CONV_ON_BIT     = 7;
	localparam int CMP_MODE_LSB    = 4;
	localparam int SAMPLE_CNT_LSB  = 0;
	localparam int GAIN_LSB        = 3;
	localparam int DIAG_PULLUP_LSB = 1;
	localparam int DIAG_INPUT_BIT  = 0;
	localparam int REF_SEL_BIT     = 5;
	localparam int VDIAG_PULLUP_LSB = 3;
	localparam int CHANNEL_LSB     = 0;
	localparam int FLAG_VACC_BIT   = 5;
	localparam int FLAG_VINST_BIT  = 4;
	localparam int FLAG_RC_BIT     = 2;
	localparam int FLAG_CACC_BIT   = 1;
	localparam int FLAG_CINST_BIT  = 0;

	// Comparator modes
	localparam logic [1:0] CMP_OFF        = 2'h0;
	localparam logic [1:0] CMP_RESET_MODE = 2'h1;
	localparam logic [1:0] CMP_UPDOWN     = 2'h2;

	// Channels that borrow the other general input as signal ground
	localparam logic [2:0] CH_IN0_SIGNAL_GROUND    = 3'h1;
	localparam logic [2:0] CH_IN1_SIGNAL_GROUND    = 3'h2;

	typedef struct packed {
		logic       current_conv_on;
		logic [2:0] current_gain_code;
		logic [1:0] current_diag_pullup_sel;
		logic       current_diag_input_sel;
		logic       voltage_conv_on;
		logic       voltage_ref_sel;
		logic [1:0] voltage_diag_pullup_sel;
		logic [2:0] voltage_channel_sel;
		logic       input1_as_signal_ground;
		logic       input0_as_signal_ground;
	} adc_cfg_t;

	typedef struct packed {
		logic volt_accum_done;
		logic volt_instant_done;
		logic curr_accum_done;
		logic curr_instant_done;
	} adc_events_t;

endpackage : adc_ctrl_pkg
